// ---- rtl/rst_defs.vh ----
`ifndef RST_DEFS_VH
`define RST_DEFS_VH

// Register byte offsets (low address byte)
`define RST_ADDR_CTRL 8'h00
`define RST_ADDR_CFG 8'h04
`define RST_ADDR_CAUSE 8'h08

// Reset cause and control bit positions
`define RST_B_PRIO 7
`define RST_B_SWBO 6
`define RST_B_MISM 5
`define RST_B_RINS 4
`define RST_B_TO 3
`define RST_B_PDN 2
`define RST_B_POR 1
`define RST_B_BRWN 0

// Value after power-on and software writable bits
`define RST_CTRL_POR_VAL 8'h7c
`define RST_CTRL_SW_MASK 8'hf3

// Brown-out configuration fields
`define RST_CFG_EN_HI 1
`define RST_CFG_EN_LO 0
`define RST_CFG_PWR_HI 3
`define RST_CFG_PWR_LO 2
`define RST_CFG_VSEL_HI 5
`define RST_CFG_VSEL_LO 4
`define RST_CFG_RST_VAL 6'h03

// Brown-out enable encodings
`define RST_BOEN_OFF 2'h0
`define RST_BOEN_SW 2'h1
`define RST_BOEN_RUN 2'h2
`define RST_BOEN_ON 2'h3

// Brown-out power modes
`define RST_BPWR_HIGH 2'h0
`define RST_BPWR_MED 2'h1
`define RST_BPWR_LOW 2'h2
`define RST_BPWR_ZERO 2'h3

// Core power-managed modes
`define RST_PM_FULL 2'h0
`define RST_PM_RUN 2'h1
`define RST_PM_IDLE 2'h2

// Last reset cause bit positions, one bit per cause
`define RST_C_POR 0
`define RST_C_PIN_RUN 1
`define RST_C_PIN_PM 2
`define RST_C_WDOG 3
`define RST_C_MISM 4
`define RST_C_BRWN 5
`define RST_C_RINS 6
`define RST_C_STKFUL 7
`define RST_C_STKUNF 8
`define RST_C_ARMED 9
`define RST_C_PINLVL 10
`define RST_CAUSE_W 11

// Bus encodings
`define RST_HTRANS_ACT_BIT 1
`define RST_WORD_W 32
`define RST_BYTE_W 8

// Timing
`define RST_CLK_MHZ 100
`define RST_PIN_FILT_NS 200
`define RST_PIN_FILT_CYC ((`RST_PIN_FILT_NS * `RST_CLK_MHZ + 999) / 1000)
// Stretch of 1000 ns at 100 MHz, sized to the counter width
`define RST_HOLD_CYC 8'd100
`define RST_CNT_W 8

`endif

// ---- rtl/rst_master_clear_pin_filter.v ----
`timescale 1ns/1ps
`default_nettype none
`include "rst_defs.vh"
module rst_pin_filter (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Raw pin level, low requests reset
  input wire pin_in,
  // Filtered reset request
  output wire asserted
);

  reg asserted_q;
  reg [`RST_CNT_W-1:0] cnt_q;
  wire differ;

  // Pin disagrees with the filtered state
  assign differ = (~pin_in) != asserted_q;

  // Only a level stable for the full filter time flips the state
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      asserted_q <= 1'b0;
      cnt_q <= {`RST_CNT_W{1'b0}};
    end
    else if (!differ)
      cnt_q <= {`RST_CNT_W{1'b0}};
    else if (cnt_q == `RST_PIN_FILT_CYC - 1)
    begin
      asserted_q <= ~asserted_q;
      cnt_q <= {`RST_CNT_W{1'b0}};
    end
    else
      cnt_q <= cnt_q + 1'b1;
  end

  assign asserted = asserted_q;

endmodule
`default_nettype wire

// ---- rtl/rst_tracker.v ----
// How it works
// - Nine reset causes are told apart in a last-cause register, one bit per cause.
// - Five low flags are changed by hardware events; software can restore bits 4, 1 and 0, not bits 3 and 2.
// - Bit 7 enables interrupt priority levels; resets to 0, read/write.
// - Bit 6 steers brown-out only when enable field is 01, else reads 0.
// - Bit 5 cleared by configuration mismatch reset; set again by software, brown-out or power-on reset.
// - Bit 4 cleared by reset instruction; set again by firmware, brown-out or power-on reset.
// - Bit 3 set by power-up, watchdog clear or sleep; cleared by watchdog time-out.
// - Bit 2 set by power-up or watchdog clear; cleared by sleep instruction.
// - Bit 1 cleared on power-on reset only; never set by hardware.
// - Bit 0 cleared by brown-out reset; only firmware sets it.
// - Master-clear pin held low forces reset; short pulses are filtered out.
// - The master-clear pin is never driven by any internal reset.
// - Supply-good rising while armed produces an internal power-on reset.
// - A two-bit field selects high, medium, low or zero-power brown-out mode.
// - Non-zero modes: brown-out resets the device; voltage field picks trip level.
// - Brown-out enabled by the enable field; the software bit takes part only when the field is 01.
// - Zero-power mode never resets on the trip itself; it re-arms power-on detection, so a power-on reset follows when the trip ends.
`timescale 1ns/1ps
`default_nettype none
`include "rst_defs.vh"
module rst_tracker (
  // Clock and true power-on reset
  input wire clk,
  input wire nrst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Master-clear pin, input only
  input wire master_clear_pin_in,
  output wire master_clear_pin_out,
  output wire master_clear_pin_oe,
  // Supply monitors
  input wire supply_good,
  input wire brownout_trip,
  output wire [1:0] brownout_power_sel,
  output wire [1:0] brownout_voltage_sel,
  output wire brownout_monitor_en,
  // Core events, one-cycle pulses except pm_mode
  input wire [1:0] pm_mode,
  input wire watchdog_timeout,
  input wire cfg_mismatch,
  input wire reset_instr,
  input wire watchdog_clear_instr,
  input wire sleep_instr,
  input wire stack_full,
  input wire stack_underflow,
  // Reset and control outputs
  output wire int_rst_n,
  output wire irq_priority_enable
);

  reg [`RST_BYTE_W-1:0] ctrl_q;
  reg [`RST_BYTE_W-1:0] ctrl_d;
  reg [5:0] cfg_q;
  reg [`RST_CAUSE_W-3:0] cause_q;
  reg [`RST_CAUSE_W-3:0] cause_d;
  reg por_armed_q;
  reg por_armed_d;
  reg pin_q;
  reg bo_act_q;
  reg [`RST_CNT_W-1:0] hold_q;
  reg [1:0] rel_q;
  reg wr_q;
  reg [7:0] addr_q;
  reg [31:0] hrdata_q;
  reg [31:0] rd_d;
  wire pin_filt;
  wire addr_ok;
  wire wr_ctrl;
  wire wr_cfg;
  wire [1:0] bo_en_cfg;
  wire zero_pwr;
  wire sleeping;
  wire bo_active;
  wire por_ev;
  wire bo_ev;
  wire pin_ev;
  wire wdog_rst_ev;
  wire any_ev;
  wire reset_req;
  wire [`RST_BYTE_W-1:0] ctrl_rd;

  // Master-clear noise filter
  // filter pin path
  rst_pin_filter u_filt (
    .clk(clk),
    .nrst(nrst),
    .pin_in(master_clear_pin_in),
    .asserted(pin_filt)
  );

  assign master_clear_pin_out = 1'b0;
  assign master_clear_pin_oe = 1'b0;

  // Bus address phase accepted when selected and active
  assign addr_ok = hsel & hready & htrans[`RST_HTRANS_ACT_BIT];
  assign wr_ctrl = wr_q & (addr_q == `RST_ADDR_CTRL);
  assign wr_cfg = wr_q & (addr_q == `RST_ADDR_CFG);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Configuration fields
  // enable, power mode and voltage select
  assign bo_en_cfg = cfg_q[`RST_CFG_EN_HI:`RST_CFG_EN_LO];
  assign brownout_power_sel = cfg_q[`RST_CFG_PWR_HI:`RST_CFG_PWR_LO];
  assign brownout_voltage_sel = cfg_q[`RST_CFG_VSEL_HI:`RST_CFG_VSEL_LO];
  assign zero_pwr = brownout_power_sel == `RST_BPWR_ZERO;
  assign sleeping = pm_mode == `RST_PM_IDLE;

  assign brownout_monitor_en = (bo_en_cfg == `RST_BOEN_ON) |
    ((bo_en_cfg == `RST_BOEN_RUN) & ~sleeping) |
    ((bo_en_cfg == `RST_BOEN_SW) & ctrl_q[`RST_B_SWBO]);
  assign bo_active = brownout_monitor_en & brownout_trip;

  // Event detection
  // power-on on supply rise
  assign por_ev = supply_good & por_armed_q & ~bo_active;
  assign bo_ev = bo_active & ~bo_act_q & ~zero_pwr;
  assign pin_ev = pin_filt & ~pin_q;
  assign wdog_rst_ev = watchdog_timeout & ~sleeping;
  assign any_ev = por_ev | bo_ev | pin_ev | wdog_rst_ev | cfg_mismatch |
    reset_instr | stack_full | stack_underflow;

  // software enable reads 0 outside 01
  assign ctrl_rd = (bo_en_cfg == `RST_BOEN_SW) ? ctrl_q :
    (ctrl_q & ~(8'h01 << `RST_B_SWBO));

  // Power-on detection arming
  always @*
  begin
    por_armed_d = por_armed_q;
    if (por_ev)
      por_armed_d = 1'b0;
    if (!supply_good)
      por_armed_d = 1'b1;
    if (bo_active & zero_pwr)
      por_armed_d = 1'b1;
  end

  // Reset cause and control register next value; events win over writes
  always @*
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = (ctrl_q & ~`RST_CTRL_SW_MASK) | (hwdata[7:0] & `RST_CTRL_SW_MASK);
    if (watchdog_clear_instr)
    begin
      ctrl_d[`RST_B_TO] = 1'b1;
      ctrl_d[`RST_B_PDN] = 1'b1;
    end
    if (sleep_instr)
    begin
      ctrl_d[`RST_B_TO] = 1'b1;
      ctrl_d[`RST_B_PDN] = 1'b0;
    end
    if (watchdog_timeout)
    begin
      ctrl_d[`RST_B_TO] = 1'b0;
      if (sleeping)
        ctrl_d[`RST_B_PDN] = 1'b0;
    end
    // Master clear in power-managed modes
    if (pin_ev & (pm_mode != `RST_PM_FULL))
    begin
      ctrl_d[`RST_B_TO] = 1'b1;
      if (sleeping)
        ctrl_d[`RST_B_PDN] = 1'b0;
    end
    if (cfg_mismatch)
      ctrl_d[`RST_B_MISM] = 1'b0;
    if (reset_instr)
      ctrl_d[`RST_B_RINS] = 1'b0;
    if (bo_ev)
    begin
      ctrl_d[`RST_B_MISM] = 1'b1;
      ctrl_d[`RST_B_RINS] = 1'b1;
      ctrl_d[`RST_B_TO] = 1'b1;
      ctrl_d[`RST_B_PDN] = 1'b1;
      ctrl_d[`RST_B_BRWN] = 1'b0;
    end
    if (any_ev)
      ctrl_d[`RST_B_PRIO] = 1'b0;
    if (por_ev)
      ctrl_d = `RST_CTRL_POR_VAL;
  end

  // Last-cause register, cleared by any event; every cause present in that cycle sets its bit
  always @*
  begin
    cause_d = cause_q;
    if (any_ev)
      cause_d = {(`RST_CAUSE_W-2){1'b0}};
    if (stack_underflow)
      cause_d[`RST_C_STKUNF] = 1'b1;
    if (stack_full)
      cause_d[`RST_C_STKFUL] = 1'b1;
    if (reset_instr)
      cause_d[`RST_C_RINS] = 1'b1;
    if (cfg_mismatch)
      cause_d[`RST_C_MISM] = 1'b1;
    if (wdog_rst_ev)
      cause_d[`RST_C_WDOG] = 1'b1;
    if (pin_ev & (pm_mode == `RST_PM_FULL))
      cause_d[`RST_C_PIN_RUN] = 1'b1;
    if (pin_ev & (pm_mode != `RST_PM_FULL))
      cause_d[`RST_C_PIN_PM] = 1'b1;
    if (bo_ev)
      cause_d[`RST_C_BRWN] = 1'b1;
    if (por_ev)
      cause_d[`RST_C_POR] = 1'b1;
  end

  // Read data for the address phase, latched for the data phase
  always @*
  begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `RST_ADDR_CTRL: rd_d[7:0] = ctrl_rd;
      `RST_ADDR_CFG: rd_d[5:0] = cfg_q;
      `RST_ADDR_CAUSE:
      begin
        rd_d[`RST_CAUSE_W-3:0] = cause_q;
        rd_d[`RST_C_ARMED] = por_armed_q;
        rd_d[`RST_C_PINLVL] = pin_filt;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Bus phase tracking and read data register
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= addr_ok & hwrite;
      addr_q <= haddr[7:0];
      if (addr_ok & ~hwrite)
        hrdata_q <= rd_d;
    end
  end

  // Flag, configuration and event-state registers
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= `RST_CTRL_POR_VAL;
      cfg_q <= `RST_CFG_RST_VAL;
      cause_q <= {(`RST_CAUSE_W-2){1'b0}};
      por_armed_q <= 1'b1;
      pin_q <= 1'b0;
      bo_act_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cause_q <= cause_d;
      por_armed_q <= por_armed_d;
      pin_q <= pin_filt;
      bo_act_q <= bo_active;
      if (wr_cfg)
        cfg_q <= hwdata[5:0];
    end
  end

  // Reset stretch counter for pulse sources
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hold_q <= `RST_HOLD_CYC;
    else if (any_ev)
      hold_q <= `RST_HOLD_CYC;
    else if (hold_q != {`RST_CNT_W{1'b0}})
      hold_q <= hold_q - 1'b1;
  end

  assign reset_req = pin_filt | (bo_active & ~zero_pwr) | ~supply_good |
    (hold_q != {`RST_CNT_W{1'b0}});

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rel_q <= 2'b00;
    else if (reset_req)
      rel_q <= 2'b00;
    else
      rel_q <= {rel_q[0], 1'b1};
  end

  assign int_rst_n = rel_q[1];
  assign irq_priority_enable = ctrl_q[`RST_B_PRIO];

endmodule
`default_nettype wire

// ---- tb/rst_tracker_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module rst_tracker_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin and monitors
  input wire logic master_clear_pin_in,
  input wire logic master_clear_pin_oe,
  input wire logic supply_good,
  input wire logic brownout_trip,
  input wire logic [1:0] brownout_power_sel,
  input wire logic brownout_monitor_en,
  // Core events
  input wire logic [1:0] pm_mode,
  input wire logic watchdog_timeout,
  input wire logic cfg_mismatch,
  input wire logic reset_instr,
  input wire logic stack_full,
  input wire logic stack_underflow,
  // Results
  input wire logic int_rst_n,
  input wire logic irq_priority_enable
);
  logic [7:0] low_q;
  logic [7:0] hold_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Saturating counts of pin low and reset low cycles
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_q <= 8'h00;
      hold_q <= 8'h00;
    end
    else
    begin
      low_q <= master_clear_pin_in ? 8'h00 : low_q + {7'h0, low_q != 8'hff};
      hold_q <= int_rst_n ? 8'h00 : hold_q + {7'h0, hold_q != 8'hff};
    end
  end
  a_pin_undriven: assert property (!master_clear_pin_oe)
    else $error("pin driven");
  a_wdog_resets: assert property (watchdog_timeout && pm_mode == 2'h0 |-> ##[1:3] !int_rst_n)
    else $error("no wdt reset");
  a_fault_resets: assert property ((cfg_mismatch || reset_instr || stack_full
    || stack_underflow) |-> ##[1:3] !int_rst_n) else $error("no event reset");
  a_master_clear_pin_hold: assert property (low_q == 8'd30 |-> !int_rst_n)
    else $error("pin low no reset");
  a_hold_len: assert property ($rose(int_rst_n) |-> hold_q >= 8'd98)
    else $error("reset too short");
  a_bo_holds: assert property ((brownout_trip && brownout_monitor_en
    && brownout_power_sel != 2'h3)[*3] |-> !int_rst_n) else $error("no bor reset");
  a_zero_no_rst: assert property (brownout_power_sel == 2'h3 && brownout_trip
    && int_rst_n && !watchdog_timeout && !reset_instr |=> int_rst_n) else $error("zp reset");
  a_supply_por: assert property ($rose(supply_good) |-> ##[1:3] !int_rst_n)
    else $error("no por");
  a_prio_clear: assert property ($fell(int_rst_n) |-> ##[0:1] !irq_priority_enable)
    else $error("prio kept");
  c_wdog: cover property (watchdog_timeout && pm_mode == 2'h0);
  c_zero_dip: cover property (brownout_power_sel == 2'h3 && brownout_trip);
  c_pin_low: cover property (low_q == 8'd30);
  c_idle_timeout: cover property (watchdog_timeout && pm_mode == 2'h2);
endmodule
bind rst_tracker rst_tracker_chk u_chk (.clk, .nrst, .master_clear_pin_in,
  .master_clear_pin_oe, .supply_good, .brownout_trip, .brownout_power_sel,
  .brownout_monitor_en, .pm_mode, .watchdog_timeout, .cfg_mismatch, .reset_instr,
  .stack_full, .stack_underflow, .int_rst_n, .irq_priority_enable);
`default_nettype wire

// ---- tb/rst_supply_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rst_supply_model (
  // Clock
  input wire logic clk,
  // Pin with pull-up and monitor levels
  output logic master_clear_pin_in,
  output logic supply_good,
  output logic brownout_trip
);
  logic [2:0] lv = 3'b011;
  // Levels leave as separate wires
  assign master_clear_pin_in = lv[0];
  assign supply_good = lv[1];
  assign brownout_trip = lv[2];
  task pulse(input int k, input int n);
  begin
    @(posedge clk);
    lv[k] <= ~lv[k];
    repeat (n) @(posedge clk);
    lv[k] <= ~lv[k];
  end
  endtask
endmodule
`default_nettype wire

// ---- tb/rst_tracker_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module rst_tracker_bench;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0, pm_mode = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [6:0] ev = 7'h00;
  wire logic hreadyout, master_clear_pin_in, supply_good, brownout_trip;
  wire logic brownout_monitor_en, int_rst_n, irq_priority_enable;
  wire logic hresp, master_clear_pin_out, master_clear_pin_oe;
  wire logic [1:0] brownout_power_sel, brownout_voltage_sel;
  int failures = 0, total_checks = 0;
  // Clock at 100 MHz
  always #5 clk = ~clk;
  rst_supply_model pm (.clk, .master_clear_pin_in, .supply_good, .brownout_trip);
  rst_tracker dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .master_clear_pin_in,
    .master_clear_pin_out, .master_clear_pin_oe, .supply_good, .brownout_trip,
    .brownout_power_sel, .brownout_voltage_sel, .brownout_monitor_en, .pm_mode,
    .watchdog_timeout(ev[0]), .cfg_mismatch(ev[1]), .reset_instr(ev[2]),
    .watchdog_clear_instr(ev[3]), .sleep_instr(ev[4]), .stack_full(ev[5]),
    .stack_underflow(ev[6]), .int_rst_n, .irq_priority_enable);
  // Compare and count
  task chk(input string n, input [31:0] e, input [31:0] g);
  begin
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // One AHB single transfer, read data left in q
  task xfer(input logic w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("resp", 0, hresp);
  end
  endtask
  task rd(input [7:0] a, input [31:0] e, input string n);
  begin
    xfer(0, a, 0);
    chk(n, e, q);
  end
  endtask
  task cause(input [8:0] e);
  begin
    xfer(0, 8'h08, 0);
    chk("cause", {23'h0, e}, q & 32'h1ff);
  end
  endtask
  // Bounded wait for the internal reset to end
  task wait_rel;
    int i;
  begin
    repeat (4) @(posedge clk);
    for (i = 0; i < 400 && int_rst_n !== 1'b1; i++)
      @(posedge clk);
    chk("released", 1, int_rst_n);
  end
  endtask
  task t_por;
  begin
    repeat (2) @(posedge clk);
    chk("por rst", 0, int_rst_n);
    wait_rel();
    rd(8'h00, 32'h3c, "flags");
    rd(8'h04, 32'h03, "cfg");
    cause(9'h001);
    xfer(1, 8'h0c, 32'hff);
    rd(8'h0c, 0, "unmapped");
    $display("test por done");
  end
  endtask
  task t_sw;
  begin
    xfer(1, 8'h00, 32'hff);
    rd(8'h00, 32'hbf, "flags");
    xfer(1, 8'h04, 32'h01);
    xfer(1, 8'h00, 32'hff);
    rd(8'h00, 32'hff, "flags sw");
    chk("mon en", 1, brownout_monitor_en);
    chk("prio", 1, irq_priority_enable);
    xfer(1, 8'h00, 32'hbf);
    @(posedge clk);
    chk("mon off", 0, brownout_monitor_en);
    for (int m = 0; m < 4; m++)
    begin
      xfer(1, 8'h04, {26'h0, m[1:0], m[1:0], 2'h3});
      @(posedge clk);
      chk("pwr", m, brownout_power_sel);
      chk("volt", m, brownout_voltage_sel);
    end
    xfer(1, 8'h04, 32'h03);
    $display("test sw done");
  end
  endtask
  // Pulse one core event from a clean flag state
  task ev_case(input int k, input [7:0] ef, input [8:0] ec);
  begin
    xfer(1, 8'h00, 32'hff);
    @(posedge clk);
    ev <= 7'h01 << k;
    @(posedge clk);
    ev <= 7'h00;
    if (ec != 0)
    begin
      repeat (3) @(posedge clk);
      chk("rst", 0, int_rst_n);
      wait_rel();
      cause(ec);
    end
    rd(8'h00, {24'h0, ef}, "flags");
  end
  endtask
  task t_ev;
  begin
    ev_case(4, 8'hbb, 0);
    ev_case(3, 8'hbf, 0);
    ev_case(2, 8'h2f, 9'h040);
    ev_case(1, 8'h1f, 9'h010);
    ev_case(5, 8'h3f, 9'h080);
    ev_case(6, 8'h3f, 9'h100);
    ev_case(0, 8'h37, 9'h008);
    ev_case(3, 8'hbf, 0);
    $display("test events done");
  end
  endtask
  task t_pin;
  begin
    pm.pulse(0, 8);
    repeat (30) @(posedge clk);
    chk("glitch", 1, int_rst_n);
    pm.pulse(0, 40);
    chk("pin oe", 0, master_clear_pin_oe);
    chk("pin out", 0, master_clear_pin_out);
    wait_rel();
    cause(9'h002);
    pm_mode <= 2'h1;
    pm.pulse(0, 40);
    wait_rel();
    cause(9'h004);
    pm_mode <= 2'h2;
    ev_case(0, 8'hb3, 0);
    chk("no rst idle", 1, int_rst_n);
    pm.pulse(0, 40);
    wait_rel();
    cause(9'h004);
    rd(8'h00, 32'h3b, "flags idle");
    pm_mode <= 2'h0;
    $display("test master_clear_pin done");
  end
  endtask
  task t_brown;
  begin
    xfer(1, 8'h00, 32'hff);
    pm.pulse(2, 30);
    wait_rel();
    cause(9'h020);
    rd(8'h00, 32'h3e, "flags");
    xfer(1, 8'h04, 32'h0f);
    xfer(1, 8'h00, 32'hff);
    pm.pulse(2, 30);
    wait_rel();
    cause(9'h001);
    rd(8'h00, 32'h3c, "flags");
    pm.pulse(1, 20);
    wait_rel();
    cause(9'h001);
    $display("test bor done");
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    t_por();
    t_sw();
    t_ev();
    t_pin();
    t_brown();
    report_and_stop();
  end
  // Hang guard
  initial
  begin
    repeat (8000) @(posedge clk);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
